// ===== design/acc_defs.svh
// Register offsets, field positions and reset values for the comparator control block.
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH

// ==========================================================================
// Register indices, byte address is four times the index (printed offsets are not all multiples of four)
// ==========================================================================
`define ACC_IDX_CMP_CTRL      8'h50
`define ACC_IDX_CONV_CTRL_B   8'h7b
`define ACC_IDX_PIN_DISABLE   8'h7f
`define ACC_IDX_IRQ_STATUS    8'h80
`define ACC_IDX_IRQ_ENABLE    8'h81
`define ACC_IDX_IRQ_CLEAR     8'h82
`define ACC_ADDR_W            12

// ==========================================================================
// Comparator control fields
// ==========================================================================
`define ACC_CC_DISABLE        7
`define ACC_CC_BANDGAP        6
`define ACC_CC_OUTPUT         5
`define ACC_CC_FLAG           4
`define ACC_CC_IRQ_EN         3
`define ACC_CC_CAPTURE        2
`define ACC_CC_MODE_HI        1
`define ACC_CC_MODE_LO        0
`define ACC_CC_RW_MASK        8'hdf

// ==========================================================================
// Converter control B and pin disable fields
// ==========================================================================
`define ACC_CB_BORROW         6
`define ACC_CB_RW_MASK        8'h47
`define ACC_PD_RW_MASK        8'h03
`define ACC_RESET_VALUE       8'h00

// ==========================================================================
// Event status bits
// ==========================================================================
`define ACC_EV_CMP            0
`define ACC_EV_TOGGLE         1
`define ACC_EV_W              2

`endif

// ===== design/acc_pkg.sv
// Types shared by the comparator control block.
package acc_pkg;

    typedef enum logic [1:0] {
        ACC_MODE_TOGGLE   = 2'b00,
        ACC_MODE_RESERVED = 2'b01,
        ACC_MODE_FALL     = 2'b10,
        ACC_MODE_RISE     = 2'b11
    } acc_mode_t;

endpackage

// ===== design/acc_sync.sv
// Two-flop synchroniser for asynchronous level inputs.
`timescale 1ns/10ps

module acc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] sync_nxt;

    initial begin
        if (WIDTH < 1) begin
            $error("acc_sync: WIDTH must be at least 1");
        end
    end

    always_comb begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r;

endmodule

// ===== design/acc_top.sv
// Comparator control block: input select, output sync, event flag, APB registers.
`timescale 1ns/10ps
`include "acc_defs.svh"

module acc_top #(
    parameter int N_CHAN = 8
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [`ACC_ADDR_W-1:0]    paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      converter_enable,
    input  wire logic [$clog2(N_CHAN)-1:0] channel_select,
    input  wire logic                      global_irq_enable,
    input  wire logic                      irq_vector_ack,
    input  wire logic                      cmp_raw_out,
    input  wire logic                      pos_pin_digital_in,
    input  wire logic                      neg_pin_digital_in,
    output logic                           neg_sel_dedicated,
    output logic      [N_CHAN-1:0]         neg_sel_channel,
    output logic                           pos_sel_bandgap,
    output logic                           comparator_power_down,
    output logic                           capture_in,
    output logic                           capture_route_active,
    output logic                           pos_pin_buf_enable,
    output logic                           neg_pin_buf_enable,
    output logic                           pos_pin_port_in,
    output logic                           neg_pin_port_in,
    output logic                           trigger_select_out_0,
    output logic                           trigger_select_out_1,
    output logic                           trigger_select_msb,
    output logic                           comparator_irq,
    output logic                           event_irq
);

    localparam int SEL_W = $clog2(N_CHAN);

    initial begin
        if (N_CHAN != 8) begin
            $error("acc_top: the channel select field serves exactly 8 channels");
        end
    end

    // ======================================================================
    // Register state
    // ======================================================================
    logic [7:0]            cmp_ctrl_r;
    logic [7:0]            cmp_ctrl_nxt;
    logic [7:0]            conv_b_r;
    logic [7:0]            conv_b_nxt;
    logic [7:0]            pin_dis_r;
    logic [7:0]            pin_dis_nxt;
    logic                  out_prev_r;
    logic                  out_prev_nxt;
    logic [`ACC_EV_W-1:0]  ev_stat_r;
    logic [`ACC_EV_W-1:0]  ev_stat_nxt;
    logic [`ACC_EV_W-1:0]  ev_en_r;
    logic [`ACC_EV_W-1:0]  ev_en_nxt;
    logic [31:0]           prdata_r;
    logic [31:0]           prdata_nxt;
    logic                  pslverr_r;
    logic                  pslverr_nxt;

    // ======================================================================
    // Synchronisers for asynchronous analog and pin inputs
    // ======================================================================
    logic [2:0] sync_q;
    logic       cmp_sync;
    logic       pos_pin_sync;
    logic       neg_pin_sync;

    acc_sync #(
        .WIDTH (3)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({neg_pin_digital_in, pos_pin_digital_in, cmp_raw_out}),
        .sync_out (sync_q)
    );

    assign cmp_sync     = sync_q[0];
    assign pos_pin_sync = sync_q[1];
    assign neg_pin_sync = sync_q[2];

    // ======================================================================
    // Bus decode
    // ======================================================================
    logic       access;
    logic       wr_acc;
    logic       setup;
    logic       rd_setup;
    logic       hit_cc;
    logic       hit_cb;
    logic       hit_pd;
    logic       hit_st;
    logic       hit_en;
    logic       hit_clr;
    logic       mapped;
    logic       lane0;

    assign access   = psel && penable;
    assign setup    = psel && !penable;
    assign wr_acc   = access && pwrite;
    assign rd_setup = setup && !pwrite;
    assign hit_cc   = (paddr == {2'b00, `ACC_IDX_CMP_CTRL, 2'b00});
    assign hit_cb   = (paddr == {2'b00, `ACC_IDX_CONV_CTRL_B, 2'b00});
    assign hit_pd   = (paddr == {2'b00, `ACC_IDX_PIN_DISABLE, 2'b00});
    assign hit_st   = (paddr == {2'b00, `ACC_IDX_IRQ_STATUS, 2'b00});
    assign hit_en   = (paddr == {2'b00, `ACC_IDX_IRQ_ENABLE, 2'b00});
    assign hit_clr  = (paddr == {2'b00, `ACC_IDX_IRQ_CLEAR, 2'b00});
    assign mapped  = hit_cc || hit_cb || hit_pd || hit_st || hit_en || hit_clr;
    assign lane0   = pstrb[0];

    // Single-cycle access phase: the slave never inserts wait states.
    assign pready  = 1'b1;
    assign prdata  = prdata_r;
    assign pslverr = pslverr_r;

    // ======================================================================
    // Comparator event detection
    // ======================================================================
    logic            rise;
    logic            fall;
    logic            cmp_event;
    logic            flag_wr_clr;
    acc_pkg::acc_mode_t mode;

    assign mode = acc_pkg::acc_mode_t'(cmp_ctrl_r[`ACC_CC_MODE_HI:`ACC_CC_MODE_LO]);
    assign rise = cmp_sync && !out_prev_r;
    assign fall = !cmp_sync && out_prev_r;

    always_comb begin
        unique case (mode)
            acc_pkg::ACC_MODE_TOGGLE:   cmp_event = rise || fall;
            acc_pkg::ACC_MODE_RESERVED: cmp_event = 1'b0;
            acc_pkg::ACC_MODE_FALL:     cmp_event = fall;
            acc_pkg::ACC_MODE_RISE:     cmp_event = rise;
        endcase
    end

    assign flag_wr_clr = wr_acc && hit_cc && lane0 && pwdata[`ACC_CC_FLAG];

    // ======================================================================
    // Register next-state logic
    // ======================================================================
    always_comb begin
        cmp_ctrl_nxt = cmp_ctrl_r;
        conv_b_nxt   = conv_b_r;
        pin_dis_nxt  = pin_dis_r;
        if (wr_acc && lane0 && hit_cc) begin
            // The flag bit is write-one-to-clear, so it is kept here and handled below.
            cmp_ctrl_nxt = (pwdata[7:0] & `ACC_CC_RW_MASK & ~(8'h01 << `ACC_CC_FLAG)) |
                           (cmp_ctrl_r & (8'h01 << `ACC_CC_FLAG));
        end
        if (wr_acc && lane0 && hit_cb) begin
            conv_b_nxt = pwdata[7:0] & `ACC_CB_RW_MASK;
        end
        if (wr_acc && lane0 && hit_pd) begin
            pin_dis_nxt = pwdata[7:0] & `ACC_PD_RW_MASK;
        end
        // Hardware set wins over both clearing paths so no event is lost.
        if (flag_wr_clr || irq_vector_ack) begin
            cmp_ctrl_nxt[`ACC_CC_FLAG] = 1'b0;
        end
        if (cmp_event) begin
            cmp_ctrl_nxt[`ACC_CC_FLAG] = 1'b1;
        end
    end

    // ======================================================================
    // Event register next-state logic
    // ======================================================================
    // The edge reference follows the synchronised output in every mode, so a
    // later mode change never mistakes a stale level for a fresh edge.
    always_comb begin
        out_prev_nxt = cmp_sync;
        ev_stat_nxt  = ev_stat_r;
        ev_en_nxt    = ev_en_r;
        if (wr_acc && lane0 && hit_en) begin
            ev_en_nxt = pwdata[`ACC_EV_W-1:0];
        end
        if (wr_acc && lane0 && hit_clr) begin
            ev_stat_nxt = ev_stat_r & ~pwdata[`ACC_EV_W-1:0];
        end
        if (cmp_event) begin
            ev_stat_nxt[`ACC_EV_CMP] = 1'b1;
        end
        if (rise || fall) begin
            ev_stat_nxt[`ACC_EV_TOGGLE] = 1'b1;
        end
    end

    // ======================================================================
    // Read data and error response
    // ======================================================================
    always_comb begin
        prdata_nxt  = prdata_r;
        pslverr_nxt = 1'b0;
        if (setup) begin
            pslverr_nxt = !mapped;
        end
        if (rd_setup) begin
            prdata_nxt = 32'h0000_0000;
            if (hit_cc) begin
                prdata_nxt[7:0] = cmp_ctrl_r;
                prdata_nxt[`ACC_CC_OUTPUT] = cmp_sync;
            end else if (hit_cb) begin
                prdata_nxt[7:0] = conv_b_r;
            end else if (hit_pd) begin
                prdata_nxt[7:0] = pin_dis_r;
            end else if (hit_st) begin
                prdata_nxt[`ACC_EV_W-1:0] = ev_stat_r;
            end else if (hit_en) begin
                prdata_nxt[`ACC_EV_W-1:0] = ev_en_r;
            end
        end
    end

    // ======================================================================
    // Bus response registers
    // ======================================================================
    // Read data and the error response are loaded at the end of the setup cycle,
    // so they stand through the whole access phase, while pready is high.
    // The cost is that a read returns the register as it was at the setup edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            prdata_r  <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // ======================================================================
    // Register state update
    // ======================================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_ctrl_r <= `ACC_RESET_VALUE;
            conv_b_r   <= `ACC_RESET_VALUE;
            pin_dis_r  <= `ACC_RESET_VALUE;
        end else begin
            cmp_ctrl_r <= cmp_ctrl_nxt;
            conv_b_r   <= conv_b_nxt;
            pin_dis_r  <= pin_dis_nxt;
        end
    end

    // The edge reference resets low with the synchroniser, so reset alone never makes an edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_prev_r <= 1'b0;
            ev_stat_r  <= '0;
            ev_en_r    <= '0;
        end else begin
            out_prev_r <= out_prev_nxt;
            ev_stat_r  <= ev_stat_nxt;
            ev_en_r    <= ev_en_nxt;
        end
    end

    // ======================================================================
    // Analog input selection
    // ======================================================================
    logic borrow;

    assign borrow            = conv_b_r[`ACC_CB_BORROW] && !converter_enable;
    assign neg_sel_dedicated = !borrow;

    genvar g;
    generate
        for (g = 0; g < N_CHAN; g = g + 1) begin : g_chan
            assign neg_sel_channel[g] = borrow && (channel_select == SEL_W'(g));
        end
    endgenerate

    assign pos_sel_bandgap       = cmp_ctrl_r[`ACC_CC_BANDGAP];
    assign comparator_power_down = cmp_ctrl_r[`ACC_CC_DISABLE];

    // ======================================================================
    // Capture routing, pin buffers and trigger select
    // ======================================================================
    assign capture_route_active = cmp_ctrl_r[`ACC_CC_CAPTURE];
    // Gated to a constant when the route is off, so the timer sees no path at all.
    assign capture_in      = cmp_ctrl_r[`ACC_CC_CAPTURE] && cmp_sync;
    logic [1:0] pin_sync;
    logic [1:0] pin_buf_en;
    logic [1:0] pin_port;

    assign pin_sync = {neg_pin_sync, pos_pin_sync};

    // A disabled pin reads zero at its port bit whatever level stands on it,
    // so a floating analog level never reaches the port logic.
    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1) begin : g_pin
            assign pin_buf_en[p] = !pin_dis_r[p];
            assign pin_port[p]   = pin_sync[p] && !pin_dis_r[p];
        end
    endgenerate

    assign pos_pin_buf_enable = pin_buf_en[0];
    assign neg_pin_buf_enable = pin_buf_en[1];
    assign pos_pin_port_in    = pin_port[0];
    assign neg_pin_port_in    = pin_port[1];
    assign trigger_select_out_0 = conv_b_r[0];
    assign trigger_select_out_1 = conv_b_r[1];
    assign trigger_select_msb   = conv_b_r[2];

    // ======================================================================
    // Interrupt outputs
    // ======================================================================
    // Software is expected to drop the enable before touching the disable or
    // mode bits; the hardware does not mask the spurious edge on its own.
    assign comparator_irq = cmp_ctrl_r[`ACC_CC_FLAG] && cmp_ctrl_r[`ACC_CC_IRQ_EN] &&
                            global_irq_enable;
    assign event_irq      = |(ev_stat_r & ev_en_r);

endmodule

// ===== tb/acc_top_sva.sv
// Port-level checks for the comparator control block.
`timescale 1ns/10ps
`include "acc_defs.svh"

module acc_top_sva #(
    parameter int N_CHAN = 8
) (
    input wire logic                      pclk,
    input wire logic                      presetn,
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pwrite,
    input wire logic [`ACC_ADDR_W-1:0]    paddr,
    input wire logic [31:0]               pwdata,
    input wire logic [3:0]                pstrb,
    input wire logic                      pready,
    input wire logic                      converter_enable,
    input wire logic [$clog2(N_CHAN)-1:0] channel_select,
    input wire logic                      global_irq_enable,
    input wire logic                      cmp_raw_out,
    input wire logic                      neg_sel_dedicated,
    input wire logic [N_CHAN-1:0]         neg_sel_channel,
    input wire logic                      pos_sel_bandgap,
    input wire logic                      comparator_power_down,
    input wire logic                      capture_in,
    input wire logic                      capture_route_active,
    input wire logic                      pos_pin_buf_enable,
    input wire logic                      neg_pin_buf_enable,
    input wire logic                      pos_pin_port_in,
    input wire logic                      neg_pin_port_in,
    input wire logic                      trigger_select_out_0,
    input wire logic                      trigger_select_out_1,
    input wire logic                      trigger_select_msb,
    input wire logic                      comparator_irq
);
    // ==========================================================
    // Shadow registers
    // ==========================================================
    localparam logic [11:0]       A_CC = `ACC_IDX_CMP_CTRL * 4;
    localparam logic [11:0]       A_CB = `ACC_IDX_CONV_CTRL_B * 4;
    localparam logic [11:0]       A_PD = `ACC_IDX_PIN_DISABLE * 4;
    localparam logic [N_CHAN-1:0] ONE  = 1;
    logic       wr_done;
    logic [7:0] cc_s;
    logic [7:0] cb_s;
    logic [1:0] pd_s;

    // Shadows follow completed writes only, so they mirror what software set.
    assign wr_done = psel && penable && pwrite && pready && pstrb[0];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cc_s <= 8'h00;
            cb_s <= 8'h00;
            pd_s <= 2'h0;
        end else if (wr_done) begin
            if (paddr == A_CC) cc_s <= pwdata[7:0];
            if (paddr == A_CB) cb_s <= pwdata[7:0];
            if (paddr == A_PD) pd_s <= pwdata[1:0];
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_neg_source: assert property (neg_sel_dedicated == !(cb_s[6] && !converter_enable))
        else $error("negative input source wrong");
    chk_neg_channel: assert property (neg_sel_channel == (neg_sel_dedicated ? '0 : ONE << channel_select))
        else $error("borrowed channel one-hot wrong");
    chk_power_down: assert property (comparator_power_down == cc_s[7])
        else $error("power down does not follow bit 7");
    chk_bandgap_sel: assert property (pos_sel_bandgap == cc_s[6])
        else $error("bandgap select does not follow bit 6");
    chk_irq_gate: assert property (comparator_irq |-> global_irq_enable && cc_s[3])
        else $error("interrupt without both enables");
    chk_capture_path: assert property ($past(presetn, 2) |-> capture_route_active == cc_s[2] && capture_in == (cc_s[2] && $past(cmp_raw_out, 2)))
        else $error("capture path wrong");
    chk_pos_disable: assert property (pos_pin_buf_enable == !pd_s[0] && (!pd_s[0] || !pos_pin_port_in))
        else $error("positive pin disable wrong");
    chk_neg_disable: assert property (neg_pin_buf_enable == !pd_s[1] && (!pd_s[1] || !neg_pin_port_in))
        else $error("negative pin disable wrong");
    chk_trig_select: assert property ({trigger_select_msb, trigger_select_out_1, trigger_select_out_0} == cb_s[2:0])
        else $error("trigger select outputs wrong");

    cover property (!neg_sel_dedicated && channel_select == 3'h7);
    cover property (comparator_irq);
    cover property ($rose(capture_in));
endmodule

bind acc_top acc_top_sva #(.N_CHAN(N_CHAN)) i_sva (.*);

// ===== tb/acc_cmp_model.sv
// Behavioural comparator core and timer capture input for the control block.
`timescale 1ns/10ps

module acc_cmp_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       pin_result,
    input  wire logic       bandgap_result,
    input  wire logic       pos_sel_bandgap,
    input  wire logic       comparator_power_down,
    input  wire logic       capture_in,
    input  wire logic       capture_route_active,
    output logic            cmp_raw_out,
    output logic [7:0]      capture_edges
);
    logic capture_d;

    // An unpowered core is held low here; real silicon gives no defined level.
    assign cmp_raw_out = comparator_power_down ? 1'b0 : (pos_sel_bandgap ? bandgap_result : pin_result);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_d     <= 1'b0;
            capture_edges <= 8'h00;
        end else begin
            capture_d <= capture_in;
            if (capture_route_active && capture_in && !capture_d) capture_edges <= capture_edges + 8'h01;
        end
    end
endmodule

// ===== tb/tb.sv
// Register-level testbench for the comparator control block.
`timescale 1ns/10ps
`include "acc_defs.svh"

module tb;
    localparam logic [11:0] CC = `ACC_IDX_CMP_CTRL * 4;
    localparam logic [11:0] CB = `ACC_IDX_CONV_CTRL_B * 4;
    localparam logic [11:0] PD = `ACC_IDX_PIN_DISABLE * 4;
    localparam logic [11:0] ES = `ACC_IDX_IRQ_STATUS * 4;
    localparam logic [11:0] EE = `ACC_IDX_IRQ_ENABLE * 4;
    localparam logic [11:0] EC = `ACC_IDX_IRQ_CLEAR * 4;
    localparam logic [3:0]  RISE_F = 4'b1001;
    localparam logic [3:0]  FALL_F = 4'b0101;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [2:0]  channel_select;
    logic [7:0]  neg_sel_channel, capture_edges;
    logic        converter_enable, global_irq_enable, irq_vector_ack, cmp_raw_out;
    logic        pos_pin_digital_in, neg_pin_digital_in, neg_sel_dedicated, pos_sel_bandgap;
    logic        comparator_power_down, capture_in, capture_route_active;
    logic        pos_pin_buf_enable, neg_pin_buf_enable, pos_pin_port_in, neg_pin_port_in;
    logic        trigger_select_out_0, trigger_select_out_1, trigger_select_msb;
    logic        comparator_irq, event_irq, pin_result, bandgap_result;
    int          fail_count, total_checks;

    acc_top i_dut (.*);
    acc_cmp_model i_cmp (.*);

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got %h want %h", $time, seen, exp);
        end
    endtask

    // Read data and the error response are taken at the edge that ends the access.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask

    task automatic rc(input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, {24'h0, exp});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge pclk);
        fail_count++;
        end_sim();
    end

    // ==========================================================
    // Test sequence
    // ==========================================================
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, converter_enable} = '0;
        {channel_select, global_irq_enable, irq_vector_ack, pin_result, bandgap_result} = '0;
        pstrb = 4'h1;
        pos_pin_digital_in = 1'b1;
        neg_pin_digital_in = 1'b1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rc(CC, 8'h00);
        rc(CB, 8'h00);
        rc(PD, 8'h00);
        wr(CC, 8'hc7);
        rc(CC, 8'hc7);
        check(32'({comparator_power_down, pos_sel_bandgap, capture_route_active}), 32'h7);
        wr(CC, 8'h00);
        wr(CB, 8'hff);
        rc(CB, 8'h47);
        check(32'({trigger_select_msb, trigger_select_out_1, trigger_select_out_0}), 32'h7);
        check(32'(neg_sel_dedicated), 32'h0);
        for (int c = 0; c < 8; c++) begin
            @(posedge pclk);
            channel_select <= 3'(c);
            tick(0);
            check(32'(neg_sel_channel), 32'h1 << c);
        end
        @(posedge pclk);
        converter_enable <= 1'b1;
        tick(0);
        check(32'({neg_sel_dedicated, neg_sel_channel}), 32'h100);
        @(posedge pclk);
        converter_enable <= 1'b0;
        wr(CB, 8'h07);
        check(32'({neg_sel_dedicated, neg_sel_channel}), 32'h100);
        wr(PD, 8'hff);
        rc(PD, 8'h03);
        check(32'({pos_pin_buf_enable, neg_pin_buf_enable, pos_pin_port_in, neg_pin_port_in}), 32'h0);
        wr(PD, 8'h01);
        tick(3);
        check(32'({pos_pin_buf_enable, neg_pin_buf_enable, pos_pin_port_in, neg_pin_port_in}), 32'h5);
        wr(PD, 8'h00);
        tick(3);
        check(32'({pos_pin_buf_enable, neg_pin_buf_enable, pos_pin_port_in, neg_pin_port_in}), 32'hf);
        for (int m = 0; m < 4; m++) begin
            wr(CC, 8'h14 | 8'(m));
            @(posedge pclk);
            pin_result <= 1'b1;
            tick(4);
            rc(CC, 8'h24 | 8'(m) | {3'h0, RISE_F[m], 4'h0});
            wr(CC, 8'h14 | 8'(m));
            @(posedge pclk);
            pin_result <= 1'b0;
            tick(4);
            rc(CC, 8'h04 | 8'(m) | {3'h0, FALL_F[m], 4'h0});
        end
        check(32'(capture_edges), 32'h4);
        wr(CC, 8'h13);
        wr(CC, 8'h0b);
        @(posedge pclk);
        global_irq_enable <= 1'b1;
        pin_result        <= 1'b1;
        tick(4);
        check(32'(comparator_irq), 32'h1);
        @(posedge pclk);
        global_irq_enable <= 1'b0;
        tick(1);
        check(32'(comparator_irq), 32'h0);
        @(posedge pclk);
        global_irq_enable <= 1'b1;
        tick(1);
        check(32'(comparator_irq), 32'h1);
        @(posedge pclk);
        irq_vector_ack <= 1'b1;
        @(posedge pclk);
        irq_vector_ack <= 1'b0;
        tick(1);
        check(32'(comparator_irq), 32'h0);
        wr(CC, 8'h03);
        wr(CC, 8'h83);
        rc(ES, 8'h03);
        wr(EE, 8'h01);
        check(32'(event_irq), 32'h1);
        wr(EE, 8'h00);
        check(32'(event_irq), 32'h0);
        wr(EC, 8'h03);
        rc(ES, 8'h00);
        rc(EC, 8'h00);
        apb(1'b0, 12'h000, 32'h0);
        check({err, rd[30:0]}, 32'h80000000);
        end_sim();
    end
endmodule
